// ===== hw/rpa_ctrl.sv
// rear park alarm controller: self test, sensor scan, proximity and fault beeps
`timescale 1ns/1ps
`default_nettype none
module rpa_ctrl
  import rpa_pkg::*;
#(
  parameter int unsigned DELAY_CYC  = DELAY_MS * CYC_PER_MS,
  parameter int unsigned CONF_CYC   = CONF_MS * CYC_PER_MS,
  parameter int unsigned SLOT_CYC   = SLOT_MS * CYC_PER_MS,
  parameter int unsigned GAP_CYC    = GAP_MS * CYC_PER_MS,
  parameter int unsigned BURST_CYC  = BURST_US * CYC_PER_US,
  parameter int unsigned RING_CYC   = RING_MIN_US * CYC_PER_US,
  parameter int unsigned CM_CYC     = CYC_PER_CM,
  parameter int unsigned LISTEN_CYC = LISTEN_CM * CYC_PER_CM
)(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ignition_on_input,
  input  wire logic        reverse_sel,
  input  wire logic [7:0]  speed_kmh,
  input  wire logic [3:0]  sens_rx,
  output logic      [3:0]  sens_tx,
  output logic             buzzer,
  output logic      [1:0]  alarm_level,
  output logic             diag_mode,
  output logic             fault_left,
  output logic             fault_right
);
  typedef enum {ST_IDLE, ST_TEST, ST_DLY, ST_CONF, ST_SCAN, ST_DIAG} rpa_st_e;
  rpa_st_e          state_ff;
  logic [1:0]       pin1_ff, pin2_ff, pin3_ff, pin_lvl_ff;
  logic             run_en_ff, busy_ff, start_ff, alt_ff, buzzer_ff;
  logic [1:0]       sel_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [3:0]       fault_ff, nxt_fault;
  logic [TOF_W-1:0] min_ff, nxt_min;
  rpa_lvl_e         lvl_ff;
  logic [TMR_W-1:0] slot_cnt_ff;
  logic [3:0]       slot_ff;
  logic [3:0]       sens_tx_ff;
  logic [15:0]      pat;
  logic             pat_bit, ping_done, round_end, ping_tx;
  rpa_ping_s        png;
  logic [TOF_W-1:0] thr_near, thr_mid, thr_far;
  assign thr_near = rpa_cm_to_cyc(NEAR_CM, CM_CYC);
  assign thr_mid  = rpa_cm_to_cyc(MID_CM, CM_CYC);
  assign thr_far  = rpa_cm_to_cyc(FAR_CM, CM_CYC);

  // ignition and reverse arrive from harness pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin1_ff    <= '0;
      pin2_ff    <= '0;
      pin3_ff    <= '0;
      pin_lvl_ff <= '0;
      run_en_ff  <= 1'b0;
    end else begin
      pin1_ff    <= {ignition_on_input, reverse_sel};
      pin2_ff    <= pin1_ff;
      pin3_ff    <= pin2_ff;
      pin_lvl_ff <= (pin3_ff & ~(pin2_ff ^ pin3_ff)) | (pin_lvl_ff & (pin2_ff ^ pin3_ff));
      run_en_ff  <= &pin_lvl_ff;
    end
  end

  rpa_ping #(
    .BURST_CYC  (BURST_CYC),
    .RING_CYC   (RING_CYC),
    .LISTEN_CYC (LISTEN_CYC)
  ) u_ping (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (start_ff),
    .rx_pin  (sens_rx[sel_ff]),
    .tx      (ping_tx),
    .res     (png)
  );
  // a ping left over from an aborted scan is ignored
  assign ping_done = png.done && busy_ff;
  assign round_end = ping_done && sel_ff == SEL_LAST;
  assign nxt_fault = fault_ff | ((ping_done && !png.ring_ok) ? (SENS_ONE << sel_ff) : '0);
  assign nxt_min   = (ping_done && png.echo && png.tof < min_ff) ? png.tof : min_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      sel_ff   <= '0;
      busy_ff  <= 1'b0;
      start_ff <= 1'b0;
      tmr_ff   <= '0;
    end else begin
      start_ff <= 1'b0;
      if (tmr_ff != '0) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
      if (!run_en_ff) begin
        state_ff <= ST_IDLE;
        busy_ff  <= 1'b0;
        sel_ff   <= '0;
        tmr_ff   <= '0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (!png.busy) begin
              state_ff <= ST_TEST;
              sel_ff   <= '0;
            end
          end
          ST_TEST, ST_SCAN: begin
            if (!busy_ff && tmr_ff == '0) begin
              start_ff <= 1'b1;
              busy_ff  <= 1'b1;
            end else if (ping_done) begin
              busy_ff <= 1'b0;
              sel_ff  <= sel_ff + 1'b1;
              // quiet gap lets the last echo die before the next burst
              tmr_ff  <= TMR_W'(GAP_CYC);
              if (round_end) begin
                if (nxt_fault != '0) begin
                  state_ff <= ST_DIAG;
                end else if (state_ff == ST_TEST) begin
                  state_ff <= ST_DLY;
                  tmr_ff   <= TMR_W'(DELAY_CYC - 1);
                end
              end
            end
          end
          ST_DLY: begin
            if (tmr_ff == '0) begin
              state_ff <= ST_CONF;
              tmr_ff   <= TMR_W'(CONF_CYC - 1);
            end
          end
          ST_CONF: begin
            if (tmr_ff == '0) begin
              state_ff <= ST_SCAN;
            end
          end
          ST_DIAG: state_ff <= ST_DIAG;
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // cleared only in ST_IDLE, ahead of each fresh self test; a failure found in the test still lands
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_ff <= '0;
    end else if (state_ff == ST_IDLE) begin
      fault_ff <= '0;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      min_ff <= '1;
      lvl_ff <= LVL_NONE;
    end else if (!run_en_ff || state_ff != ST_SCAN) begin
      min_ff <= '1;
      lvl_ff <= LVL_NONE;
    end else if (round_end) begin
      min_ff <= '1;
      if (speed_kmh > SPEED_MAX_KMH) begin
        lvl_ff <= LVL_NONE;
      end else begin
        lvl_ff <= lvl_of(nxt_min, thr_near, thr_mid, thr_far);
      end
    end else begin
      min_ff <= nxt_min;
    end
  end

  // exact cycle counts keep every beep far inside the ten percent window
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slot_cnt_ff <= '0;
      slot_ff     <= '0;
      alt_ff      <= 1'b0;
    end else if (slot_cnt_ff == TMR_W'(SLOT_CYC - 1)) begin
      slot_cnt_ff <= '0;
      slot_ff     <= slot_ff + 1'b1;
      if (slot_ff == 4'hf) begin
        alt_ff <= ~alt_ff;
      end
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 1'b1;
    end
  end
  always_comb begin
    pat = '0;
    case (state_ff)
      ST_SCAN: begin
        case (lvl_ff)
          LVL_FAR:  pat = PAT_FAR;
          LVL_MID:  pat = PAT_MID;
          LVL_NEAR: pat = PAT_NEAR;
          default:  pat = '0;
        endcase
      end
      ST_DIAG: begin
        // both sides failed: alternate the two patterns
        if ((fault_ff & RIGHT_MASK) != '0 && ((fault_ff & LEFT_MASK) == '0 || alt_ff)) begin
          pat = PAT_RIGHT;
        end else if ((fault_ff & LEFT_MASK) != '0) begin
          pat = PAT_LEFT;
        end
      end
      default: pat = '0;
    endcase
    pat_bit = pat[~slot_ff];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      buzzer_ff  <= 1'b0;
      sens_tx_ff <= '0;
    end else begin
      buzzer_ff  <= run_en_ff && (state_ff == ST_CONF || pat_bit);
      // an aborted ping keeps bursting internally; keep it off the pins
      sens_tx_ff <= (ping_tx && busy_ff) ? (SENS_ONE << sel_ff) : '0;
    end
  end

  assign sens_tx     = sens_tx_ff;
  assign buzzer      = buzzer_ff;
  assign alarm_level = lvl_ff;
  assign diag_mode   = state_ff == ST_DIAG;
  assign fault_left  = |(fault_ff & LEFT_MASK);
  assign fault_right = |(fault_ff & RIGHT_MASK);
  sequence s_lvl_round;
    run_en_ff && state_ff == ST_SCAN && round_end && speed_kmh <= SPEED_MAX_KMH;
  endsequence
  sequence s_dly_to_conf;
    (state_ff == ST_DLY && run_en_ff) ##1 (state_ff == ST_CONF && run_en_ff);
  endsequence
  property p_quiet_off_rev;
    @(posedge mclk) disable iff (sys_rst) !run_en_ff |=> !buzzer_ff;
  endproperty
  a_quiet_off_rev: assert property (p_quiet_off_rev) else $error("buzzer outside reverse");
  property p_tx_sel;
    @(posedge mclk) disable iff (sys_rst)
      (sens_tx_ff != '0) |-> sens_tx_ff == (SENS_ONE << $past(sel_ff));
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("burst on unselected sensor");
  property p_lvl_near;
    @(posedge mclk) disable iff (sys_rst)
      s_lvl_round ##0 (nxt_min <= thr_near) |=> lvl_ff == LVL_NEAR;
  endproperty
  a_lvl_near: assert property (p_lvl_near) else $error("near level missed");
  property p_lvl_mid;
    @(posedge mclk) disable iff (sys_rst)
      s_lvl_round ##0 (nxt_min > thr_near && nxt_min <= thr_mid) |=> lvl_ff == LVL_MID;
  endproperty
  a_lvl_mid: assert property (p_lvl_mid) else $error("mid level missed");
  property p_lvl_far;
    @(posedge mclk) disable iff (sys_rst)
      s_lvl_round ##0 (nxt_min > thr_mid && nxt_min <= thr_far) |=> lvl_ff == LVL_FAR;
  endproperty
  a_lvl_far: assert property (p_lvl_far) else $error("far level missed");
  property p_speed_gate;
    @(posedge mclk) disable iff (sys_rst)
      (round_end && speed_kmh > SPEED_MAX_KMH) |=> lvl_ff == LVL_NONE;
  endproperty
  a_speed_gate: assert property (p_speed_gate) else $error("alarm above speed limit");
  property p_confirm;
    @(posedge mclk) disable iff (sys_rst) s_dly_to_conf |-> !buzzer_ff ##1 buzzer_ff;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirmation beep misplaced");
  property p_diag_entry;
    @(posedge mclk) disable iff (sys_rst)
      (run_en_ff && (state_ff == ST_TEST || state_ff == ST_SCAN) && round_end
       && nxt_fault != '0) |=> diag_mode;
  endproperty
  a_diag_entry: assert property (p_diag_entry) else $error("fault without diag mode");
  property p_left_pat;
    @(posedge mclk) disable iff (sys_rst)
      (diag_mode && run_en_ff && fault_left && !fault_right)
        |=> buzzer_ff == PAT_LEFT[~$past(slot_ff)];
  endproperty
  a_left_pat: assert property (p_left_pat) else $error("left fault pattern wrong");
  property p_right_pat;
    @(posedge mclk) disable iff (sys_rst)
      (diag_mode && run_en_ff && fault_right && !fault_left)
        |=> buzzer_ff == PAT_RIGHT[~$past(slot_ff)];
  endproperty
  a_right_pat: assert property (p_right_pat) else $error("right fault pattern wrong");
  property p_silent_far;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_SCAN && lvl_ff == LVL_NONE && !round_end) |=> !buzzer_ff;
  endproperty
  a_silent_far: assert property (p_silent_far) else $error("buzzer with no object");
  property p_slot_bound;
    @(posedge mclk) disable iff (sys_rst) slot_cnt_ff < TMR_W'(SLOT_CYC);
  endproperty
  a_slot_bound: assert property (p_slot_bound) else $error("beep slot overran");
endmodule : rpa_ctrl
`default_nettype wire

// ===== hw/rpa_ping.sv
// rear park alarm package and single-sensor ping engine
// Contract
// - Detection and buzzer run only while reverse is selected, silent otherwise.
// - Drive each sensor with a transmit burst, then watch that sensor's receive input.
// - Derive distance from echo timing and choose one of three alarm levels.
// - First alarm level for nearest object at 81 to 120 cm, 15 cm tolerance.
// - Second alarm level for nearest object at 41 to 80 cm, 10 cm tolerance.
// - Third alarm level for nearest object within 40 cm, 10 cm tolerance.
// - Proximity alarms only while reversing or approach speed is at most 10 km/h.
// - All buzzer waveform timings within ten percent of nominal.
// - Self check passes: wait 0.5 s, then one 0.3 s confirmation beep.
// - On a detected failure enter diagnostic mode and report the failed location.
// - Sensor good only if ringing above 3 V lasts over 0.8 ms, else failed.
// - Left sensor fault: three evenly spaced single beeps.
// - Right sensor fault: three groups of paired beeps.
// - Distance is half of echo time times 340 m/s.
package rpa_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned SOUND_MPS   = 340;
  localparam int unsigned CM_PER_M    = 100;
  // round trip: one cm of range costs two cm of flight
  localparam int unsigned CYC_PER_CM  = (2 * CLK_HZ) / (SOUND_MPS * CM_PER_M);
  localparam int unsigned RING_MIN_US = 800;
  localparam int unsigned TX_HZ       = 40_000;
  localparam int unsigned TX_HALF_CYC = CLK_HZ / (2 * TX_HZ);
  localparam int unsigned BURST_US    = 200;
  localparam int unsigned NEAR_CM     = 40;
  localparam int unsigned MID_CM      = 80;
  localparam int unsigned FAR_CM      = 120;
  localparam int unsigned LISTEN_CM   = 135;
  localparam int unsigned DELAY_MS    = 500;
  localparam int unsigned CONF_MS     = 300;
  localparam int unsigned SLOT_MS     = 50;
  localparam int unsigned GAP_MS      = 10;
  localparam logic [7:0]  SPEED_MAX_KMH = 8'h0a;
  localparam int unsigned TOF_W  = 24;
  localparam int unsigned TMR_W  = 27;
  localparam int unsigned SENS_N = 4;
  localparam logic [1:0]  SEL_LAST   = 2'h3;
  // sensor order: rear-left, side-left, rear-right, side-right
  localparam logic [3:0]  LEFT_MASK  = 4'h3;
  localparam logic [3:0]  RIGHT_MASK = 4'hc;
  localparam logic [3:0]  SENS_ONE   = 4'h1;
  // 16 slots per pattern, msb first
  localparam logic [15:0] PAT_FAR   = 16'hc0c0;
  localparam logic [15:0] PAT_MID   = 16'hcccc;
  localparam logic [15:0] PAT_NEAR  = 16'hffff;
  localparam logic [15:0] PAT_LEFT  = 16'hc30c;
  localparam logic [15:0] PAT_RIGHT = 16'ha528;

  typedef enum logic [1:0] {LVL_NONE, LVL_FAR, LVL_MID, LVL_NEAR} rpa_lvl_e;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic             ring_ok;
    logic             echo;
    logic [TOF_W-1:0] tof;
  } rpa_ping_s;

  // range in cm to echo flight time in cycles
  function automatic logic [TOF_W-1:0] rpa_cm_to_cyc(input int unsigned cm,
                                                      input int unsigned cyc_per_cm);
    rpa_cm_to_cyc = TOF_W'(cm * cyc_per_cm);
  endfunction : rpa_cm_to_cyc

  // closest band first, so any sensor inside 40 cm wins
  function automatic rpa_lvl_e lvl_of(input logic [TOF_W-1:0] tof,
                                      input logic [TOF_W-1:0] t_near,
                                      input logic [TOF_W-1:0] t_mid,
                                      input logic [TOF_W-1:0] t_far);
    if (tof <= t_near) lvl_of = LVL_NEAR;
    else if (tof <= t_mid) lvl_of = LVL_MID;
    else if (tof <= t_far) lvl_of = LVL_FAR;
    else lvl_of = LVL_NONE;
  endfunction : lvl_of
endpackage : rpa_pkg

`timescale 1ns/1ps
`default_nettype none
module rpa_ping
  import rpa_pkg::*;
#(
  parameter int unsigned BURST_CYC  = BURST_US * CYC_PER_US,
  parameter int unsigned RING_CYC   = RING_MIN_US * CYC_PER_US,
  parameter int unsigned LISTEN_CYC = LISTEN_CM * CYC_PER_CM
)(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire logic      start,
  input  wire logic      rx_pin,
  output logic           tx,
  output rpa_ping_s      res
);
  typedef enum {PG_IDLE, PG_BURST, PG_RING, PG_LISTEN} rpa_pg_e;

  rpa_pg_e          st_ff;
  logic             rx1_ff, rx2_ff, rx3_ff, rx_lvl_ff;
  logic [TOF_W-1:0] tof_ff;
  logic [TOF_W-1:0] ring_cnt_ff;
  logic [11:0]      half_ff;
  logic             tx_ff, done_ff, ring_ok_ff, echo_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx1_ff    <= 1'b0;
      rx2_ff    <= 1'b0;
      rx3_ff    <= 1'b0;
      rx_lvl_ff <= 1'b0;
    end else begin
      rx1_ff <= rx_pin;
      rx2_ff <= rx1_ff;
      rx3_ff <= rx2_ff;
      if (rx2_ff == rx3_ff) begin
        rx_lvl_ff <= rx3_ff;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff       <= PG_IDLE;
      tof_ff      <= '0;
      ring_cnt_ff <= '0;
      half_ff     <= '0;
      tx_ff       <= 1'b0;
      done_ff     <= 1'b0;
      ring_ok_ff  <= 1'b0;
      echo_ff     <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (st_ff != PG_IDLE) begin
        tof_ff <= tof_ff + 1'b1;
      end
      case (st_ff)
        PG_IDLE: begin
          if (start) begin
            st_ff       <= PG_BURST;
            tof_ff      <= '0;
            ring_cnt_ff <= '0;
            half_ff     <= '0;
            tx_ff       <= 1'b1;
            ring_ok_ff  <= 1'b0;
            echo_ff     <= 1'b0;
          end
        end
        PG_BURST: begin
          if (half_ff == 12'(TX_HALF_CYC - 1)) begin
            half_ff <= '0;
            tx_ff   <= ~tx_ff;
          end else begin
            half_ff <= half_ff + 1'b1;
          end
          if (tof_ff >= TOF_W'(BURST_CYC - 1)) begin
            st_ff <= PG_RING;
            tx_ff <= 1'b0;
          end
        end
        PG_RING: begin
          // saturate one past the limit so "longer than" is exact
          if (rx_lvl_ff && ring_cnt_ff <= TOF_W'(RING_CYC)) begin
            ring_cnt_ff <= ring_cnt_ff + 1'b1;
          end
          if (!rx_lvl_ff) begin
            st_ff      <= PG_LISTEN;
            ring_ok_ff <= ring_cnt_ff > TOF_W'(RING_CYC);
          end else if (tof_ff >= TOF_W'(LISTEN_CYC - 1)) begin
            st_ff      <= PG_IDLE;
            ring_ok_ff <= 1'b1;
            done_ff    <= 1'b1;
          end
        end
        PG_LISTEN: begin
          if (rx_lvl_ff) begin
            st_ff   <= PG_IDLE;
            echo_ff <= 1'b1;
            done_ff <= 1'b1;
          end else if (tof_ff >= TOF_W'(LISTEN_CYC - 1)) begin
            st_ff   <= PG_IDLE;
            done_ff <= 1'b1;
          end
        end
        default: st_ff <= PG_IDLE;
      endcase
    end
  end

  assign tx          = tx_ff;
  assign res.busy    = (st_ff != PG_IDLE) || done_ff;
  assign res.done    = done_ff;
  assign res.ring_ok = ring_ok_ff;
  assign res.echo    = echo_ff;
  assign res.tof     = tof_ff;

  property p_ring_judge;
    @(posedge mclk) disable iff (sys_rst)
      (st_ff == PG_RING && !rx_lvl_ff) |=>
        (ring_ok_ff == ($past(ring_cnt_ff) > TOF_W'(RING_CYC)));
  endproperty
  a_ring_judge: assert property (p_ring_judge) else $error("ring length misjudged");
endmodule : rpa_ping
`default_nettype wire

// ===== bench/rpa_sens_model.sv
// four rear ultrasonic transducers answering the transmit drive with ring and echo envelopes
`timescale 1ns/1ps
`default_nettype none
module rpa_sens_model
  import rpa_pkg::*;
#(
  parameter int unsigned BURST_CYC  = 100,
  parameter int unsigned RING_CYC   = 80,
  parameter int unsigned CM_CYC     = 10,
  parameter int unsigned LISTEN_CYC = 1350
)(
  input  wire logic        mclk,
  input  wire logic [3:0]  sens_tx,
  input  wire logic [3:0]  ring_bad,
  input  wire logic [31:0] echo_cm,
  output wire logic [3:0]  sens_rx
);
  localparam int unsigned ECHO_LEN = 30;

  for (genvar g = 0; g < SENS_N; g++) begin : g_sens
    logic        act_ff  = 1'b0;
    logic        tx_d_ff = 1'b0;
    logic        rx_ff   = 1'b0;
    int unsigned t_ff    = 0;
    int unsigned ring_end;
    int unsigned echo_at;
    int unsigned act_end;
    logic        has_echo;

    // a broken lead rings for well under the good-connection minimum
    assign ring_end = BURST_CYC + (ring_bad[g] ? RING_CYC / 2 : RING_CYC + 20);
    assign echo_at  = int'(echo_cm[8*g +: 8]) * CM_CYC;
    assign has_echo = (echo_cm[8*g +: 8] != 8'h00);
    // short activity window so the next ping of this sensor is never missed
    assign act_end  = has_echo ? echo_at + ECHO_LEN : LISTEN_CYC + 20;

    always_ff @(posedge mclk) begin
      tx_d_ff <= sens_tx[g];
      // a fresh burst restarts the envelope even while the last one fades
      if (sens_tx[g] && !tx_d_ff && (!act_ff || t_ff >= BURST_CYC)) begin
        act_ff <= 1'b1;
        t_ff   <= 0;
      end else if (act_ff) begin
        t_ff <= t_ff + 1;
        if (t_ff >= act_end) begin
          act_ff <= 1'b0;
        end
      end
    end

    always_ff @(posedge mclk) begin
      if (act_ff && t_ff < ring_end) begin
        rx_ff <= 1'b1;
      end else if (act_ff && has_echo && t_ff >= echo_at && t_ff < echo_at + ECHO_LEN) begin
        rx_ff <= 1'b1;
      end else begin
        rx_ff <= 1'b0;
      end
    end

    assign sens_rx[g] = rx_ff;
  end
endmodule : rpa_sens_model
`default_nettype wire

// ===== bench/rpa_ctrl_test.sv
// self-checking bench for the rear park alarm controller
`timescale 1ns/1ps
`default_nettype none
module rpa_ctrl_test;
  import rpa_pkg::*;
  localparam int unsigned SLOT   = 50;
  localparam int unsigned DLY    = 500;
  localparam int unsigned CONF   = 300;
  localparam int unsigned LISTEN = 1350;
  localparam int unsigned GAP    = 20;
  localparam int unsigned BURST  = 100;
  localparam int unsigned RING   = 80;
  localparam int unsigned CMC    = 10;
  localparam logic [31:0] ECHO_TAB [9] = '{32'h76767676, 32'h2b2b2b2b, 32'h53535353,
    32'h26262626, 32'h3c3c3c3c, 32'h3c3c3c3c, 32'h3c3c3c3c, 32'h64641e64, 32'h00000000};
  localparam logic [7:0]  SPD_TAB [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0b, 8'h0a,
    8'h00, 8'h00};
  localparam logic [1:0]  LVL_TAB [9] = '{2'h1, 2'h2, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h0};

  logic        mclk = 1'b0;
  logic        sys_rst;
  logic        ignition_on_input;
  logic        reverse_sel;
  logic [7:0]  speed_kmh;
  wire  [3:0]  sens_rx;
  logic [3:0]  sens_tx;
  logic        buzzer;
  logic [1:0]  alarm_level;
  logic        diag_mode;
  logic        fault_left;
  logic        fault_right;
  logic [3:0]  ring_bad;
  logic [31:0] echo_cm;
  int          failures  = 0;
  int          cmp_count = 0;

  always #5 mclk = ~mclk;

  rpa_ctrl #(.DELAY_CYC(DLY), .CONF_CYC(CONF), .SLOT_CYC(SLOT), .GAP_CYC(GAP),
    .BURST_CYC(BURST), .RING_CYC(RING), .CM_CYC(CMC), .LISTEN_CYC(LISTEN)) i_rpa_ctrl (
    .mclk(mclk), .sys_rst(sys_rst), .ignition_on_input(ignition_on_input),
    .reverse_sel(reverse_sel), .speed_kmh(speed_kmh), .sens_rx(sens_rx), .sens_tx(sens_tx),
    .buzzer(buzzer), .alarm_level(alarm_level), .diag_mode(diag_mode),
    .fault_left(fault_left), .fault_right(fault_right));

  rpa_sens_model #(.BURST_CYC(BURST), .RING_CYC(RING), .CM_CYC(CMC), .LISTEN_CYC(LISTEN))
    i_rpa_sens_model (.mclk(mclk), .sens_tx(sens_tx), .ring_bad(ring_bad), .echo_cm(echo_cm),
    .sens_rx(sens_rx));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] lvl_pat(input logic [1:0] l);
    case (l)
      2'h1:    lvl_pat = PAT_FAR;
      2'h2:    lvl_pat = PAT_MID;
      2'h3:    lvl_pat = PAT_NEAR;
      default: lvl_pat = 16'h0000;
    endcase
  endfunction : lvl_pat

  // slot counter free-runs, so any rotation of the pattern is acceptable
  task automatic chk_pat(input logic [15:0] pat);
    logic        b;
    int          n;
    logic [15:0] cap;
    logic [15:0] r;
    logic        hit;
    b = buzzer;
    n = 0;
    while (buzzer === b && n < 16 * SLOT) begin
      @(negedge mclk);
      n++;
    end
    repeat (SLOT / 2) @(negedge mclk);
    for (int i = 15; i >= 0; i--) begin
      cap[i] = buzzer;
      repeat (SLOT) @(negedge mclk);
    end
    r = pat;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (r === cap) hit = 1'b1;
      r = {r[14:0], r[15]};
    end
    cmp_count++;
    if (!hit) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, cap, pat);
    end
  endtask : chk_pat

  task automatic wait_sig(input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (sens_tx !== exp && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_sig

  task automatic t_idle();
    logic seen;
    seen = 1'b0;
    ignition_on_input = 1'b0;
    reverse_sel = 1'b1;
    repeat (400) begin
      @(negedge mclk);
      if (sens_tx !== 4'h0 || buzzer !== 1'b0) seen = 1'b1;
    end
    check(seen, 1'b0);
  endtask : t_idle

  task automatic t_selftest();
    int n;
    ignition_on_input = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wait_sig(4'h0, 3000);
      n = 0;
      while (sens_tx === 4'h0 && n < 3000) begin
        @(negedge mclk);
        n++;
      end
      check(sens_tx, SENS_ONE << i);
    end
    wait_sig(4'h0, 3000);
    n = 0;
    while (buzzer !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check(n >= DLY && n <= DLY + LISTEN + 10, 1'b1);
    n = 0;
    while (buzzer === 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check(n, CONF);
    check({diag_mode, fault_left, fault_right}, 3'h0);
  endtask : t_selftest

  task automatic t_level(input int k);
    int n;
    echo_cm = ECHO_TAB[k];
    speed_kmh = SPD_TAB[k];
    n = 0;
    while (alarm_level !== LVL_TAB[k] && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    check(alarm_level, LVL_TAB[k]);
    chk_pat(lvl_pat(LVL_TAB[k]));
  endtask : t_level

  task automatic t_drop();
    reverse_sel = 1'b0;
    repeat (20) @(negedge mclk);
    check({sens_tx, buzzer, alarm_level, diag_mode, fault_left, fault_right}, 10'h000);
    repeat (200) @(negedge mclk);
  endtask : t_drop

  task automatic t_fault(input logic [3:0] bad, input logic [1:0] flags, input logic [15:0] pat);
    int n;
    t_drop();
    ring_bad = bad;
    reverse_sel = 1'b1;
    n = 0;
    while (diag_mode !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    check({diag_mode, fault_left, fault_right}, {1'b1, flags});
    chk_pat(pat);
    ring_bad = 4'h0;
  endtask : t_fault

  initial begin
    sys_rst = 1'b1;
    ignition_on_input = 1'b0;
    reverse_sel = 1'b0;
    speed_kmh = 8'h00;
    ring_bad = 4'h0;
    echo_cm = 32'h00000000;
    repeat (20) @(negedge mclk);
    check({sens_tx, buzzer, alarm_level, diag_mode, fault_left, fault_right}, 10'h000);
    sys_rst = 1'b0;
    t_idle();
    t_selftest();
    for (int k = 0; k < 9; k++) begin
      t_level(k);
    end
    t_fault(4'h1, 2'h2, PAT_LEFT);
    t_fault(4'h4, 2'h1, PAT_RIGHT);
    t_drop();
    print_verdict();
  end

  // full sequence needs about 60k cycles
  initial begin
    #1_000_000;
    failures++;
    print_verdict();
  end
endmodule : rpa_ctrl_test
`default_nettype wire
